/* hdl/alu_exec_pkg.sv */
package alu_exec_pkg;
  // ==========================================================
  // Instruction word layout
  // ==========================================================
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int FADDR_W = 5;
  localparam int PC_BIT8 = 8;
  localparam int DEST_BIT = 5;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [5:0] OP_ADD_WF = 6'h07;
  localparam logic [5:0] OP_AND_WF = 6'h05;
  localparam logic [3:0] OP_AND_LW = 4'hE;
  localparam logic [2:0] OP_BRANCH = 3'h5;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [3:0] OP_RET_LIT = 4'h8;
  localparam logic [8:0] OP_LOAD_DIR = 9'h000;
  localparam logic [2:0] OP_MOV_WF = 3'h1;
  // ==========================================================
  // File register addresses
  // ==========================================================
  localparam logic [4:0] ADDR_PCL = 5'h02;
  localparam logic [4:0] ADDR_TIMER = 5'h01;
  localparam logic [4:0] ADDR_PORT_A = 5'h05;
  localparam logic [4:0] ADDR_PORT_B = 5'h06;
  localparam logic [4:0] ADDR_PORT_C = 5'h07;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage : alu_exec_pkg

/* hdl/alu_exec.sv */
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// ==========================================================
// Execute-stage datapath for add and AND, with port side effects
// ==========================================================
module alu_exec (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [alu_exec_pkg::INSN_W-1:0] insn,
  input wire logic [alu_exec_pkg::DATA_W-1:0] file_rdata,
  input wire logic [alu_exec_pkg::DATA_W-1:0] port_a_in,
  input wire logic [alu_exec_pkg::DATA_W-1:0] port_b_in,
  input wire logic [alu_exec_pkg::DATA_W-1:0] port_c_in,
  input wire logic prescaler_on_timer,
  input wire logic [alu_exec_pkg::PC_W-1:0] pc_target,
  input wire logic pc_load,
  output logic [alu_exec_pkg::FADDR_W-1:0] file_addr,
  output logic insn_fetch,
  output logic [alu_exec_pkg::DATA_W-1:0] file_wdata,
  output logic file_we,
  output logic [alu_exec_pkg::DATA_W-1:0] work,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic [alu_exec_pkg::PC_W-1:0] program_counter,
  output logic prescaler_clear,
  output logic [alu_exec_pkg::DATA_W-1:0] port_a_out,
  output logic [alu_exec_pkg::DATA_W-1:0] port_a_oe_n,
  output logic [alu_exec_pkg::DATA_W-1:0] port_b_out,
  output logic [alu_exec_pkg::DATA_W-1:0] port_b_oe_n,
  output logic [alu_exec_pkg::DATA_W-1:0] port_c_out,
  output logic [alu_exec_pkg::DATA_W-1:0] port_c_oe_n
);
  import alu_exec_pkg::*;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } state_t;

  typedef struct packed {
    state_t st;
    logic [1:0] phase;
    logic [DATA_W-1:0] w;
    logic c;
    logic dc;
    logic z;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic psc_clr;
    logic [DATA_W-1:0] lat_a;
    logic [DATA_W-1:0] lat_b;
    logic [DATA_W-1:0] lat_c;
    logic [DATA_W-1:0] dir_a;
    logic [DATA_W-1:0] dir_b;
    logic [DATA_W-1:0] dir_c;
  } core_t;

  core_t s_reg;
  core_t s_next;

  // Fetch a new word on the last oscillator phase of each cycle.
  function automatic logic last_phase(input logic [1:0] ph);
    return ph == PHASE_LAST;
  endfunction

  function automatic logic is_port(input logic [FADDR_W-1:0] a);
    return a == ADDR_PORT_A || a == ADDR_PORT_B || a == ADDR_PORT_C;
  endfunction

  logic [FADDR_W-1:0] faddr;
  logic dest_file;
  logic [DATA_W-1:0] src;
  logic [DATA_W:0] sum;
  logic [4:0] low_sum;
  logic [DATA_W-1:0] result;
  logic is_add;
  logic is_andf;
  logic is_andl;
  logic is_dir;
  logic writes_file;

  assign faddr = insn[FADDR_W-1:0];
  assign dest_file = insn[DEST_BIT];
  assign is_add = insn[11:6] == OP_ADD_WF;
  assign is_andf = insn[11:6] == OP_AND_WF;
  assign is_andl = insn[11:8] == OP_AND_LW;
  assign is_dir = insn[11:3] == OP_LOAD_DIR;

  // Ports read back as the pin levels, so an input pin held low by the
  // outside world is written back as zero even if its latch holds one.
  always_comb begin
    case (faddr)
      ADDR_PORT_A: src = port_a_in;
      ADDR_PORT_B: src = port_b_in;
      ADDR_PORT_C: src = port_c_in;
      default: src = file_rdata;
    endcase
  end

  assign sum = {1'b0, s_reg.w} + {1'b0, src};
  assign low_sum = {1'b0, s_reg.w[3:0]} + {1'b0, src[3:0]};
  assign writes_file = (is_add || is_andf) && dest_file;

  always_comb begin
    if (is_add) begin
      result = sum[DATA_W-1:0];
    end else if (is_andf) begin
      result = s_reg.w & src;
    end else begin
      result = s_reg.w & insn[DATA_W-1:0];
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.phase = s_reg.phase + 2'h1;
    s_next.we = 1'b0;
    s_next.psc_clr = 1'b0;
    case (s_reg.st)
      ST_EXEC: begin
        if (last_phase(s_reg.phase)) begin
          s_next.pc = s_reg.pc + 11'h001;
          if (is_add || is_andf || is_andl) begin
            s_next.z = result == ZERO8;
            if (is_add) begin
              s_next.c = sum[DATA_W];
              s_next.dc = low_sum[4];
            end
            if (writes_file) begin
              s_next.wdata = result;
              s_next.we = 1'b1;
              if (faddr == ADDR_TIMER) begin
                s_next.psc_clr = prescaler_on_timer;
              end
              case (faddr)
                ADDR_PORT_A: s_next.lat_a = result;
                ADDR_PORT_B: s_next.lat_b = result;
                ADDR_PORT_C: s_next.lat_c = result;
                default: ;
              endcase
            end else begin
              s_next.w = result;
            end
          end
          if (is_dir) begin
            case (faddr)
              ADDR_PORT_A: s_next.dir_a = s_reg.w;
              ADDR_PORT_B: s_next.dir_b = s_reg.w;
              ADDR_PORT_C: s_next.dir_c = s_reg.w;
              default: ;
            endcase
          end
          if (pc_load) begin
            s_next.pc = pc_target;
            if (insn[11:9] != OP_BRANCH) begin
              s_next.pc[PC_BIT8] = 1'b0;
            end
            s_next.st = ST_FLUSH;
          end else if (writes_file && faddr == ADDR_PCL) begin
            s_next.pc = {s_reg.pc[PC_W-1:PC_BIT8+1], 1'b0, result};
            s_next.st = ST_FLUSH;
          end
        end
      end
      ST_FLUSH: begin
        if (last_phase(s_reg.phase)) begin
          s_next.st = ST_EXEC;
        end
      end
      default: s_next.st = ST_EXEC;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: ST_EXEC, phase: 2'h0, w: ZERO8, c: 1'b0, dc: 1'b0,
                 z: 1'b0, pc: '1, wdata: ZERO8, we: 1'b0, psc_clr: 1'b0,
                 lat_a: ZERO8, lat_b: ZERO8, lat_c: ZERO8,
                 dir_a: DIR_RESET, dir_b: DIR_RESET, dir_c: DIR_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  assign file_addr = faddr;
  assign insn_fetch = last_phase(s_reg.phase);
  assign file_wdata = s_reg.wdata;
  assign file_we = s_reg.we;
  assign work = s_reg.w;
  assign carry_flag = s_reg.c;
  assign digit_carry_flag = s_reg.dc;
  assign zero_flag = s_reg.z;
  assign program_counter = s_reg.pc;
  assign prescaler_clear = s_reg.psc_clr;
  assign port_a_out = s_reg.lat_a;
  assign port_b_out = s_reg.lat_b;
  assign port_c_out = s_reg.lat_c;
  // A direction bit of one releases the pin; enable is active low.
  assign port_a_oe_n = s_reg.dir_a;
  assign port_b_oe_n = s_reg.dir_b;
  assign port_c_oe_n = s_reg.dir_c;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_pc_bit8;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && pc_load &&
       insn[11:9] != OP_BRANCH) |=> !program_counter[PC_BIT8];
  endproperty
  a_pc_bit8: assert property (p_pc_bit8)
    else $error("program counter bit 8 not cleared");

  // Checks the latched write-back, so a source mux that picked the latch
  // instead of the pins would be caught.
  property p_port_src;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && is_andf &&
       dest_file && faddr == ADDR_PORT_B)
      |=> port_b_out == ($past(work) & $past(port_b_in));
  endproperty
  a_port_src: assert property (p_port_src)
    else $error("port operand not taken from pins");

  property p_dir_load;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && is_dir &&
       faddr == ADDR_PORT_C) |=> port_c_oe_n == $past(work);
  endproperty
  a_dir_load: assert property (p_dir_load)
    else $error("direction latch not loaded from W");

  property p_psc;
    @(posedge mclk) disable iff (rst)
      prescaler_clear |-> $past(faddr == ADDR_TIMER && writes_file &&
                                prescaler_on_timer);
  endproperty
  a_psc: assert property (p_psc)
    else $error("prescaler clear without timer write");

  property p_andl;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && is_andl &&
       !pc_load) |=> work == ($past(work) & $past(insn[7:0])) &&
       zero_flag == (work == ZERO8);
  endproperty
  a_andl: assert property (p_andl)
    else $error("literal AND wrong");

  property p_dest;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && is_andf &&
       dest_file) |=> file_we && work == $past(work);
  endproperty
  a_dest: assert property (p_dest)
    else $error("destination select ignored");

  property p_add;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && is_add &&
       !dest_file && !pc_load) |=> {carry_flag, work} ==
       ({1'b0, $past(work)} + {1'b0, $past(src)});
  endproperty
  a_add: assert property (p_add)
    else $error("add result or carry wrong");

  property p_andf_flags;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && last_phase(s_reg.phase) && is_andf)
      |=> carry_flag == $past(carry_flag) &&
          digit_carry_flag == $past(digit_carry_flag);
  endproperty
  a_andf_flags: assert property (p_andf_flags)
    else $error("AND touched carry flags");

  property p_cycle;
    @(posedge mclk) disable iff (rst)
      insn_fetch |=> !insn_fetch [*3] ##1 insn_fetch;
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("instruction cycle not four periods");

  property p_single;
    @(posedge mclk) disable iff (rst)
      (s_reg.st == ST_EXEC && insn_fetch && is_andl && !pc_load)
      |=> s_reg.st == ST_EXEC;
  endproperty
  a_single: assert property (p_single)
    else $error("AND literal took a second cycle");

endmodule // alu_exec

/* test/test_w_register_logic_ops.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the add and AND execute datapath
// ==========================================================
module test_w_register_logic_ops;
  import alu_exec_pkg::*;
  logic mclk;
  logic rst;
  logic [INSN_W-1:0] insn;
  logic [DATA_W-1:0] file_rdata;
  logic [DATA_W-1:0] port_a_in;
  logic [DATA_W-1:0] port_b_in;
  logic [DATA_W-1:0] port_c_in;
  logic prescaler_on_timer;
  logic [PC_W-1:0] pc_target;
  logic pc_load;
  logic [FADDR_W-1:0] file_addr;
  logic insn_fetch;
  logic [DATA_W-1:0] file_wdata;
  logic file_we;
  logic [DATA_W-1:0] work;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic [PC_W-1:0] program_counter;
  logic prescaler_clear;
  logic [DATA_W-1:0] port_a_out;
  logic [DATA_W-1:0] port_a_oe_n;
  logic [DATA_W-1:0] port_b_out;
  logic [DATA_W-1:0] port_b_oe_n;
  logic [DATA_W-1:0] port_c_out;
  logic [DATA_W-1:0] port_c_oe_n;
  int miscompares;
  int n_checks;
  logic [2:0] flags;
  logic [23:0] oe_all;

  assign flags = {carry_flag, digit_carry_flag, zero_flag};
  assign oe_all = {port_a_oe_n, port_b_oe_n, port_c_oe_n};

`define CHK(nm, ex, got) begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

  alu_exec dut_u (.mclk(mclk), .rst(rst), .insn(insn),
    .file_rdata(file_rdata), .port_a_in(port_a_in),
    .port_b_in(port_b_in), .port_c_in(port_c_in),
    .prescaler_on_timer(prescaler_on_timer), .pc_target(pc_target),
    .pc_load(pc_load), .file_addr(file_addr), .insn_fetch(insn_fetch),
    .file_wdata(file_wdata), .file_we(file_we), .work(work),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag), .program_counter(program_counter),
    .prescaler_clear(prescaler_clear), .port_a_out(port_a_out),
    .port_a_oe_n(port_a_oe_n), .port_b_out(port_b_out),
    .port_b_oe_n(port_b_oe_n), .port_c_out(port_c_out),
    .port_c_oe_n(port_c_oe_n));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] fop(logic [5:0] op, logic d,
                                      logic [4:0] a);
    return {op, d, a};
  endfunction

  // Returns at the rising edge on which the current word executes.
  task automatic wait_fetch();
    int k;
    k = 0;
    while (insn_fetch !== 1'b1 && k < 8) begin
      @(negedge mclk);
      k++;
    end
    if (insn_fetch !== 1'b1) begin
      miscompares++;
      final_report();
    end
    @(posedge mclk);
  endtask

  // The word is held for its whole slot, then a no-op fills the gap.
  task automatic exec(input logic [11:0] i, input logic [7:0] f,
                      input logic pl, input logic [10:0] pt);
    wait_fetch();
    insn <= i;
    file_rdata <= f;
    pc_load <= pl;
    pc_target <= pt;
    @(negedge mclk);
    `CHK("file_addr", i[4:0], file_addr)
    wait_fetch();
    insn <= 12'h000;
    pc_load <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic t_add();
    logic [7:0] fv[6] = '{8'h17, 8'hC2, 8'h27, 8'h17, 8'hC2, 8'h3E};
    logic [7:0] wv[6] = '{8'h17, 8'hD9, 8'h00, 8'h17, 8'hD9, 8'h17};
    logic [2:0] cv[6] = '{3'h0, 3'h0, 3'h7, 3'h0, 3'h0, 3'h6};
    for (int n = 0; n < 6; n++) begin
      exec(fop(OP_ADD_WF, 1'b0, 5'h08), fv[n], 1'b0, 11'h000);
      `CHK("work", wv[n], work)
      `CHK("flags", cv[n], flags)
      `CHK("file_we", 1'b0, file_we)
    end
  endtask

  task automatic t_and();
    exec(fop(OP_AND_WF, 1'b1, 5'h08), 8'hE8, 1'b0, 11'h000);
    `CHK("file_wdata", 8'h00, file_wdata)
    `CHK("file_we", 1'b1, file_we)
    `CHK("flags", 3'h7, flags)
    `CHK("work", 8'h17, work)
    @(negedge mclk);
    `CHK("file_we", 1'b0, file_we)
    exec(fop(OP_AND_WF, 1'b0, 5'h08), 8'hC2, 1'b0, 11'h000);
    `CHK("work", 8'h02, work)
    `CHK("flags", 3'h6, flags)
    exec({OP_AND_LW, 8'h5F}, 8'h00, 1'b0, 11'h000);
    `CHK("work", 8'h02, work)
    exec({OP_AND_LW, 8'hFD}, 8'h00, 1'b0, 11'h000);
    `CHK("work", 8'h00, work)
    `CHK("flags", 3'h7, flags)
  endtask

  // The file read data is all ones while the pins differ, so the pins must win.
  task automatic t_port();
    exec(fop(OP_ADD_WF, 1'b0, 5'h08), 8'h5A, 1'b0, 11'h000);
    for (int p = 0; p < 3; p++) begin
      exec(fop(OP_AND_WF, 1'b1, ADDR_PORT_A + 5'(p)), 8'hFF, 1'b0, 11'h0);
    end
    `CHK("port_a_out", 8'h0A, port_a_out)
    `CHK("port_b_out", 8'h18, port_b_out)
    `CHK("port_c_out", 8'h50, port_c_out)
  endtask

  task automatic t_dir();
    exec({OP_LOAD_DIR, 3'h4}, 8'h00, 1'b0, 11'h000);
    `CHK("oe_n", 24'hFFFFFF, oe_all)
    for (int p = 0; p < 3; p++) begin
      exec({OP_LOAD_DIR, 3'(5 + p)}, 8'h00, 1'b0, 11'h000);
    end
    `CHK("oe_n", 24'h5A5A5A, oe_all)
  endtask

  task automatic t_timer();
    logic [2:0] cs[3] = '{3'b111, 3'b010, 3'b100};
    for (int n = 0; n < 3; n++) begin
      @(posedge mclk);
      prescaler_on_timer <= cs[n][1];
      @(negedge mclk);
      exec(fop(OP_ADD_WF, cs[n][2], ADDR_TIMER), 8'h00, 1'b0, 11'h000);
      `CHK("prescaler_clear", cs[n][0], prescaler_clear)
    end
  endtask

  task automatic t_cycle();
    logic [PC_W-1:0] p;
    int cnt;
    p = program_counter;
    cnt = 0;
    repeat (8) begin
      @(negedge mclk);
      cnt += (insn_fetch === 1'b1) ? 1 : 0;
    end
    `CHK("fetches", 2, cnt)
    `CHK("program_counter", p + 11'd2, program_counter)
  endtask

  task automatic t_pc();
    exec({OP_CALL, 8'h00}, 8'h00, 1'b1, 11'h1FF);
    `CHK("program_counter", 11'h0FF, program_counter)
    exec({OP_BRANCH, 9'h1AB}, 8'h00, 1'b1, 11'h1AB);
    `CHK("program_counter", 11'h1AB, program_counter)
    exec(fop(OP_ADD_WF, 1'b1, ADDR_PCL), 8'h10, 1'b0, 11'h000);
    `CHK("program_counter", 9'h06A, program_counter[8:0])
  endtask

  initial begin
    miscompares = 0;
    n_checks = 0;
    rst = 1'b1;
    insn = 12'h000;
    file_rdata = 8'h00;
    port_a_in = 8'h0F;
    port_b_in = 8'h3C;
    port_c_in = 8'hF0;
    prescaler_on_timer = 1'b0;
    pc_target = 11'h000;
    pc_load = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK("oe_n", 24'hFFFFFF, oe_all)
    t_add();
    t_and();
    t_port();
    t_dir();
    t_timer();
    t_cycle();
    t_pc();
    final_report();
  end
endmodule // test_w_register_logic_ops
